// File: verilog/scsd_cfg.svh
// Constants for the system clock select and divide block
`ifndef SCSD_CFG_SVH
`define SCSD_CFG_SVH

// Register offsets on the plain register port
`define SCSD_ADDR_W          8
`define SCSD_OFS_CHIP_CTRL   8'h9F
`define SCSD_OFS_PWR_MON     8'hAC
`define SCSD_OFS_CLK_CFG     8'hC0
`define SCSD_OFS_CLK_STATUS  8'hC1

// Reset values
`define SCSD_RST_CLK_CFG     8'hFF
`define SCSD_RST_CHIP_CTRL   8'h01
`define SCSD_RST_PWR_MON     8'h00
`define SCSD_RD_ZERO         8'h00

// Chip control fields
`define SCSD_CC_SOFTWARE_RESET_TRIG_BIT    7
`define SCSD_CC_INSYSTEM_PROG_EN_BIT    0
`define SCSD_CC_RW_MASK      8'h73

// Power monitor control fields
`define SCSD_PM_BROWNOUT_DETECT_EN_BIT    7
`define SCSD_PM_BROWNOUT_RESET_EN_BIT    4
`define SCSD_PM_BOF_BIT      3
`define SCSD_PM_LOWPOWER_BROWNOUT_EN_BIT    2
`define SCSD_PM_BOS_BIT      0
`define SCSD_PM_RW_MASK      8'h9C

// Clock config reserved bits read as one
`define SCSD_CFG_RSVD_MASK   8'h05

// Timing: input filter and slow brown-out sampling
`define SCSD_REF_CLK_MHZ     200
`define SCSD_FILT_NS         20
`define SCSD_FILT_LEN        ((`SCSD_FILT_NS * `SCSD_REF_CLK_MHZ + 999) / 1000)
`define SCSD_LP_RC_HZ        10000
`define SCSD_BOD_INTERVAL_US 12800
`define SCSD_BOD_TICKS       ((`SCSD_BOD_INTERVAL_US * `SCSD_LP_RC_HZ) / 1000000)

// Machine cycle: six core ticks in either cycle mode
`define SCSD_TICKS_PER_MC    6

`endif

// File: verilog/scsd_pkg.sv
// Types for the system clock select and divide block
package scsd_pkg;

    // Clock configuration byte layout, bit 7 first
    typedef struct packed {
        logic cfg_watchdog_en;
        logic cycle_mode_sel;
        logic crystal_gain_sel;
        logic input_clk_filter_en;
        logic rc_freq_sel;
        logic rsvd2;
        logic osc_source_sel;
        logic rsvd0;
    } scsd_cfg_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } scsd_req_t;

    // Configuration load sequence
    typedef enum logic [1:0] {
        SCSD_LOAD = 2'b00,
        SCSD_RUN  = 2'b01
    } scsd_load_t;

    // Brown-out sensing mode
    typedef enum logic [1:0] {
        SCSD_BOD_OFF  = 2'b00,
        SCSD_BOD_CONT = 2'b01,
        SCSD_BOD_LP   = 2'b10
    } scsd_bod_t;

endpackage

// File: verilog/scsd_tick_div2.sv
// Divide-by-two stage on a tick stream, with bypass
`timescale 1ns/1ps
module scsd_tick_div2
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic tick_in,
    input  wire logic bypass,
    output logic      tick_out
);

    logic phase_ff;    // Alternates on each input tick
    logic tick_out_ff; // Registered output tick

    // Phase toggles on every input tick, bypass or not
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_ff <= 1'b0;
        else if (tick_in)
            phase_ff <= ~phase_ff;
    end

    // Pass every tick when bypassed, every second one otherwise
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_out_ff <= 1'b0;
        else
            tick_out_ff <= tick_in & (bypass | phase_ff);
    end

    assign tick_out = tick_out_ff;

endmodule

// File: verilog/scsd_top.sv
// System clock source select, dividers, gain and filter control
//
// Overview of operation
// - Source bit one picks crystal, zero RC
// - RC select one bypasses halving, zero halves
// - Cycle mode one halves core clock, 12T
// - Cycle mode zero bypasses halving, 6T
// - Filter enable one filters crystal input
// - Gain bit one normal, zero reduced
// - Programming enable starts the fast RC
// - Low-power bit honoured only with detection on
// - Low-power mode samples every 12.8ms via 10kHz
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "scsd_cfg.svh"
module scsd_top
    import scsd_pkg::*;
#(
    parameter int FILT_LEN  = `SCSD_FILT_LEN,
    parameter int BOD_TICKS = `SCSD_BOD_TICKS
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       crystal_in_pin,
    output logic            crystal_out_pin,
    input  wire logic       rc_osc_tick,
    input  wire logic       lp_rc_tick,
    input  wire logic       brownout_state,
    output logic            sys_osc_tick,
    output logic            cpu_tick,
    output logic            periph_tick,
    output logic            mcycle_tick,
    output logic            rc_osc_run,
    output logic            lp_rc_run,
    output logic            crystal_amp_en,
    output logic            crystal_gain_sel,
    output logic            filter_active,
    output logic            isp_clk_tick,
    output logic            bod_sense_on,
    output logic            bod_sample,
    output logic            software_reset_trig
);

    // Refuse parameter values the logic cannot serve
    generate
        if (FILT_LEN < 2 || FILT_LEN > 64)
        begin : g_bad_filt
            $error("FILT_LEN out of range");
        end
        if (BOD_TICKS < 2 || BOD_TICKS > 65535)
        begin : g_bad_bod
            $error("BOD_TICKS out of range");
        end
    endgenerate

    localparam int BCW = $clog2(BOD_TICKS);
    localparam logic [BCW-1:0] BOD_LAST = BCW'(BOD_TICKS - 1);
    localparam logic [2:0] MC_LAST = 3'(`SCSD_TICKS_PER_MC - 1);

    scsd_req_t  req;              // Bundled register request
    scsd_cfg_t  cfg_prog_ff = scsd_cfg_t'(`SCSD_RST_CLK_CFG); // Programmed config, survives rst_n
    scsd_cfg_t  cfg_act_ff;       // Active config, frozen while running
    scsd_load_t load_st_ff;       // Config load sequence state
    scsd_load_t nxt_load_st;
    logic [7:0] chip_ctrl_ff;     // Chip control storage
    logic [7:0] pwr_mon_ff;       // Power monitor control storage
    logic [7:0] rdata_ff;         // Read data, valid one cycle after strobe
    logic       software_reset_trig_ff;         // Software reset pulse
    logic       running;          // Config loaded, clocks may run

    logic [FILT_LEN-1:0] samp_ff; // Crystal input sample history
    logic [FILT_LEN-1:0] samp_in; // Pin and taps, each feeding the next tap
    logic       filt_lvl_ff;      // Filtered crystal level
    logic       raw_lvl_ff;       // Unfiltered crystal level
    logic       path_lvl;         // Level after filter select
    logic       path_lvl_d_ff;    // Previous path level for edge detect
    logic       xtal_tick_ff;     // One pulse per crystal rising edge
    logic       xtal_out_ff;      // Inverting amplifier output
    logic       rc_sel_tick;      // RC tick after optional halving
    logic       osc_tick;         // Selected oscillator tick
    logic       sys_tick_ff;      // Registered oscillator tick
    logic       core_tick;        // Core and peripheral tick
    logic [2:0] mc_cnt_ff;        // Core ticks in this machine cycle
    logic       mc_tick_ff;       // Machine cycle boundary
    logic       isp_on;           // Programming function enabled
    logic       isp_tick_ff;      // RC tick for programming timing

    scsd_bod_t  bod_st_ff;        // Brown-out sensing mode
    scsd_bod_t  nxt_bod_st;
    logic [BCW-1:0] bod_cnt_ff;   // Slow RC ticks since last sample
    logic       bod_sample_ff;    // One-cycle sample strobe

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Load sequence: copy programmed config once after reset release
    always_comb
    begin
        nxt_load_st = load_st_ff;
        case (load_st_ff)
            SCSD_LOAD: nxt_load_st = SCSD_RUN;
            SCSD_RUN:  nxt_load_st = SCSD_RUN;
            default:   nxt_load_st = SCSD_LOAD;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            load_st_ff <= SCSD_LOAD;
        else
            load_st_ff <= nxt_load_st;
    end

    assign running = (load_st_ff == SCSD_RUN);

    // Active config taken only in the load state, so no run-time switch
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_act_ff <= scsd_cfg_t'(`SCSD_RST_CLK_CFG);
        else if (load_st_ff == SCSD_LOAD)
            cfg_act_ff <= cfg_prog_ff;
    end

    // Programmed config byte; no rst_n, so it outlives the reset that loads it
    // Limitation: a write here only takes effect after the next reset
    always_ff @(posedge ref_clk)
    begin
        if (req.wr && req.addr == `SCSD_OFS_CLK_CFG)
            cfg_prog_ff <= scsd_cfg_t'(req.wdata | `SCSD_CFG_RSVD_MASK);
    end

    // Chip control: read-write bits stored, reset trigger is a pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            chip_ctrl_ff <= `SCSD_RST_CHIP_CTRL;
        else if (req.wr && req.addr == `SCSD_OFS_CHIP_CTRL)
            chip_ctrl_ff <= req.wdata & `SCSD_CC_RW_MASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            software_reset_trig_ff <= 1'b0;
        else
            software_reset_trig_ff <= req.wr && req.addr == `SCSD_OFS_CHIP_CTRL && req.wdata[`SCSD_CC_SOFTWARE_RESET_TRIG_BIT];
    end

    // Power monitor control; state bit is read live from the detector
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr_mon_ff <= `SCSD_RST_PWR_MON;
        else if (req.wr && req.addr == `SCSD_OFS_PWR_MON)
            pwr_mon_ff <= req.wdata & `SCSD_PM_RW_MASK;
    end

    // Read mux; unmapped addresses return zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= `SCSD_RD_ZERO;
        else if (!req.rd)
            rdata_ff <= `SCSD_RD_ZERO;
        else
        begin
            case (req.addr)
                `SCSD_OFS_CHIP_CTRL:  rdata_ff <= chip_ctrl_ff;
                `SCSD_OFS_PWR_MON:
                begin
                    rdata_ff <= pwr_mon_ff;
                    rdata_ff[`SCSD_PM_BOS_BIT] <= brownout_state;
                end
                `SCSD_OFS_CLK_CFG:    rdata_ff <= cfg_prog_ff;
                `SCSD_OFS_CLK_STATUS: rdata_ff <= cfg_act_ff;
                default:              rdata_ff <= `SCSD_RD_ZERO;
            endcase
        end
    end

    // Crystal input sample history, one flop per tap
    assign samp_in = {samp_ff[FILT_LEN-2:0], crystal_in_pin};
    genvar gi;
    generate
        for (gi = 0; gi < FILT_LEN; gi++)
        begin : g_samp
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    samp_ff[gi] <= 1'b0;
                else
                    samp_ff[gi] <= samp_in[gi];
            end
        end
    endgenerate

    // Filter: level moves only when all taps agree, so short spikes die
    // Trade-off: adds FILT_LEN cycles of latency to every edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            filt_lvl_ff <= 1'b0;
        else if (&samp_ff)
            filt_lvl_ff <= 1'b1;
        else if (~|samp_ff)
            filt_lvl_ff <= 1'b0;
    end

    // Unfiltered level, one register to match the first tap
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            raw_lvl_ff <= 1'b0;
        else
            raw_lvl_ff <= crystal_in_pin;
    end

    // Filter select on the crystal input path
    assign path_lvl = cfg_act_ff.input_clk_filter_en ? filt_lvl_ff : raw_lvl_ff;

    // Rising-edge detect makes one tick per crystal cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            path_lvl_d_ff <= 1'b0;
            xtal_tick_ff  <= 1'b0;
        end
        else
        begin
            path_lvl_d_ff <= path_lvl;
            xtal_tick_ff  <= path_lvl & ~path_lvl_d_ff;
        end
    end

    // Inverting amplifier drive, idle when the crystal is not the source
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            xtal_out_ff <= 1'b0;
        else
            xtal_out_ff <= running & cfg_act_ff.osc_source_sel & ~crystal_in_pin;
    end

    // RC halving stage, bypassed for the fast setting
    scsd_tick_div2 u_rc_div
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tick_in  (rc_osc_tick & running),
        .bypass   (cfg_act_ff.rc_freq_sel),
        .tick_out (rc_sel_tick)
    );

    // Source select between crystal path and internal RC
    assign osc_tick = running & (cfg_act_ff.osc_source_sel ? xtal_tick_ff : rc_sel_tick);

    // Registered oscillator tick, aligned with the core divider output
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sys_tick_ff <= 1'b0;
        else
            sys_tick_ff <= osc_tick;
    end

    // Core divider: halves in 12T mode, bypassed in 6T mode
    scsd_tick_div2 u_core_div
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tick_in  (osc_tick),
        .bypass   (~cfg_act_ff.cycle_mode_sel),
        .tick_out (core_tick)
    );

    // Machine cycle: six core ticks, twelve or six oscillator clocks
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mc_cnt_ff  <= 3'h0;
            mc_tick_ff <= 1'b0;
        end
        else
        begin
            mc_tick_ff <= core_tick && mc_cnt_ff == MC_LAST;
            if (core_tick)
                mc_cnt_ff <= (mc_cnt_ff == MC_LAST) ? 3'h0 : mc_cnt_ff + 3'h1;
        end
    end

    // Programming enable is active low in chip control
    assign isp_on = ~chip_ctrl_ff[`SCSD_CC_INSYSTEM_PROG_EN_BIT];

    // Fast RC ticks to the programming timer, never halved
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            isp_tick_ff <= 1'b0;
        else
            isp_tick_ff <= isp_on & rc_osc_tick;
    end

    // Brown-out mode: low-power bit only counts when detection is on
    always_comb
    begin
        nxt_bod_st = SCSD_BOD_OFF;
        case ({pwr_mon_ff[`SCSD_PM_BROWNOUT_DETECT_EN_BIT], pwr_mon_ff[`SCSD_PM_LOWPOWER_BROWNOUT_EN_BIT]})
            2'b10:   nxt_bod_st = SCSD_BOD_CONT;
            2'b11:   nxt_bod_st = SCSD_BOD_LP;
            default: nxt_bod_st = SCSD_BOD_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            bod_st_ff <= SCSD_BOD_OFF;
        else
            bod_st_ff <= nxt_bod_st;
    end

    // Sample interval counted on the slow RC; restarts on mode entry
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bod_cnt_ff    <= '0;
            bod_sample_ff <= 1'b0;
        end
        else if (bod_st_ff != SCSD_BOD_LP)
        begin
            bod_cnt_ff    <= '0;
            bod_sample_ff <= 1'b0;
        end
        else
        begin
            bod_sample_ff <= lp_rc_tick && bod_cnt_ff == BOD_LAST;
            if (lp_rc_tick)
                bod_cnt_ff <= (bod_cnt_ff == BOD_LAST) ? '0 : bod_cnt_ff + 1'b1;
        end
    end

    // Oscillator enables and analog controls
    assign rc_osc_run      = running & (~cfg_act_ff.osc_source_sel | isp_on);
    assign lp_rc_run       = (bod_st_ff == SCSD_BOD_LP);
    assign bod_sense_on    = (bod_st_ff == SCSD_BOD_CONT);
    assign crystal_amp_en  = running & cfg_act_ff.osc_source_sel;
    assign crystal_gain_sel = cfg_act_ff.crystal_gain_sel;
    assign filter_active   = cfg_act_ff.input_clk_filter_en;

    // Output wiring
    assign crystal_out_pin     = xtal_out_ff;
    assign reg_rdata           = rdata_ff;
    assign sys_osc_tick        = sys_tick_ff;
    assign cpu_tick            = core_tick;
    assign periph_tick         = core_tick;
    assign mcycle_tick         = mc_tick_ff;
    assign isp_clk_tick        = isp_tick_ff;
    assign bod_sample          = bod_sample_ff;
    assign software_reset_trig = software_reset_trig_ff;

endmodule

// File: tb/scsd_props.sv
// Port-level timing checks for the clock select block
`timescale 1ns/1ps
module scsd_props
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       crystal_in_pin,
    input wire logic       crystal_out_pin,
    input wire logic       rc_osc_tick,
    input wire logic       sys_osc_tick,
    input wire logic       cpu_tick,
    input wire logic       periph_tick,
    input wire logic       mcycle_tick,
    input wire logic       rc_osc_run,
    input wire logic       lp_rc_run,
    input wire logic       crystal_amp_en,
    input wire logic       crystal_gain_sel,
    input wire logic       filter_active,
    input wire logic       isp_clk_tick,
    input wire logic       bod_sense_on,
    input wire logic       bod_sample
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Amplifier on for two samples, so the output flop has seen it
    sequence s_xtal_run;
        crystal_amp_en && $past(crystal_amp_en);
    endsequence

    // Two edges past release, so the load has landed
    sequence s_loaded;
        $past(rst_n, 2);
    endsequence

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its answer cycle");
    a_periph_cpu_eq: assert property (periph_tick == cpu_tick)
        else $error("peripheral tick differs from core tick");
    a_cpu_on_osc: assert property (cpu_tick |-> sys_osc_tick)
        else $error("core tick without oscillator tick");
    a_mcycle_spacing: assert property (mcycle_tick |-> $past(cpu_tick) ##1 !mcycle_tick [*5])
        else $error("machine cycle tick misplaced");
    a_xtal_out_inv: assert property (s_xtal_run |-> crystal_out_pin == !$past(crystal_in_pin))
        else $error("amplifier output not inverted input");
    a_rc_src_run: assert property (s_loaded and !crystal_amp_en |-> rc_osc_run)
        else $error("fast RC idle while selected");
    a_isp_tick_src: assert property (isp_clk_tick |-> $past(rc_osc_tick) && $past(rc_osc_run))
        else $error("programming tick without RC tick");
    a_bod_mode_excl: assert property (!(lp_rc_run && bod_sense_on))
        else $error("both brown-out modes on");
    a_bod_sample_lp: assert property (bod_sample |-> $past(lp_rc_run))
        else $error("brown-out sample outside low-power mode");
    a_cfg_static: assert property (s_loaded |-> $stable(crystal_gain_sel) && $stable(filter_active)
        && $stable(crystal_amp_en))
        else $error("clock setting changed at run time");
endmodule

bind scsd_top scsd_props i_props (.ref_clk, .rst_n, .reg_rd, .reg_rdata, .crystal_in_pin, .crystal_out_pin,
    .rc_osc_tick, .sys_osc_tick, .cpu_tick, .periph_tick, .mcycle_tick, .rc_osc_run, .lp_rc_run,
    .crystal_amp_en, .crystal_gain_sel, .filter_active, .isp_clk_tick, .bod_sense_on, .bod_sample);

// File: tb/scsd_osc_model.sv
// Crystal and on-chip oscillator sources facing the block
`timescale 1ns/1ps
module scsd_osc_model
(
    input  wire logic       ref_clk,
    input  wire logic [3:0] xtal_half,
    input  wire logic [3:0] rc_per,
    input  wire logic [3:0] lp_per,
    input  wire logic       glitch,
    input  wire logic       rc_run,
    input  wire logic       lp_run,
    output logic            crystal_in_pin,
    output logic            rc_osc_tick = 1'b0,
    output logic            lp_rc_tick = 1'b0
);
    logic [3:0] xc_ff  = 4'h0; // Crystal half-period count
    logic [3:0] rc_ff  = 4'h0; // Fast RC period count
    logic [3:0] lp_ff  = 4'h0; // Slow RC period count
    logic       lvl_ff = 1'b0; // Crystal level

    // Noise pulse flips the pin while held
    assign crystal_in_pin = lvl_ff ^ glitch;

    // Crystal; zero half period stops it, 5 or more keeps it under 24MHz
    always @(posedge ref_clk)
    begin
        if (xtal_half == 4'h0)
            xc_ff <= 4'h0;
        else if (xc_ff >= xtal_half - 4'h1)
        begin
            xc_ff  <= 4'h0;
            lvl_ff <= !lvl_ff;
        end
        else
            xc_ff <= xc_ff + 4'h1;
    end

    // Fast RC ticks only while enabled
    always @(posedge ref_clk)
    begin
        rc_osc_tick <= 1'b0;
        if (!rc_run)
            rc_ff <= 4'h0;
        else if (rc_ff >= rc_per - 4'h1)
        begin
            rc_ff       <= 4'h0;
            rc_osc_tick <= 1'b1;
        end
        else
            rc_ff <= rc_ff + 4'h1;
    end

    // Slow RC ticks only while enabled
    always @(posedge ref_clk)
    begin
        lp_rc_tick <= 1'b0;
        if (!lp_run)
            lp_ff <= 4'h0;
        else if (lp_ff >= lp_per - 4'h1)
        begin
            lp_ff      <= 4'h0;
            lp_rc_tick <= 1'b1;
        end
        else
            lp_ff <= lp_ff + 4'h1;
    end
endmodule

// File: tb/system_clock_select_divide_tb_top.sv
// Self-checking bench for the clock select and divide block
`timescale 1ns/1ps
`include "scsd_cfg.svh"
module system_clock_select_divide_tb_top
    import scsd_pkg::*;
;
    localparam int N = 600; // Counting window in cycles
    logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, glitch = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       brownout_state = 1'b0;
    logic [3:0] xtal_half = 4'h6, rc_per = 4'h3, lp_per = 4'h3;
    logic       crystal_in_pin, crystal_out_pin, rc_osc_tick, lp_rc_tick, sys_osc_tick, cpu_tick;
    logic       periph_tick, mcycle_tick, rc_osc_run, lp_rc_run, crystal_amp_en, crystal_gain_sel;
    logic       filter_active, isp_clk_tick, bod_sense_on, bod_sample, software_reset_trig;
    logic [31:0] seed = 32'd34; // Fixed seed keeps runs repeatable
    int         fails = 0, checks = 0;
    int         n[5]; // Pulse counts: osc, cpu, mcycle, programming, sample

    // Short filter and sample interval keep the run brief
    scsd_top #(.FILT_LEN(2), .BOD_TICKS(4)) i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .crystal_in_pin, .crystal_out_pin, .rc_osc_tick, .lp_rc_tick, .brownout_state,
        .sys_osc_tick, .cpu_tick, .periph_tick, .mcycle_tick, .rc_osc_run, .lp_rc_run, .crystal_amp_en,
        .crystal_gain_sel, .filter_active, .isp_clk_tick, .bod_sense_on, .bod_sample, .software_reset_trig);

    scsd_osc_model i_osc (.ref_clk, .xtal_half, .rc_per, .lp_per, .glitch, .rc_run(rc_osc_run),
        .lp_run(lp_rc_run), .crystal_in_pin, .rc_osc_tick, .lp_rc_tick);

    // Clock at 200MHz
    initial
        forever #2.5 ref_clk = ~ref_clk;

    // Cut a hang short
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        summarize();
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Counts measured over a window are good to one pulse
    function automatic logic near(int a, int b);
        return a >= b - 1 && a <= b + 1;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic cnt(input int len);
        n = '{default: 0};
        repeat (len)
        begin
            @(posedge ref_clk);
            n[0] += int'(sys_osc_tick);
            n[1] += int'(cpu_tick);
            n[2] += int'(mcycle_tick);
            n[3] += int'(isp_clk_tick);
            n[4] += int'(bod_sample);
        end
    endtask

    initial
    begin
        logic [7:0] d, r, act;
        scsd_cfg_t  c;
        logic [7:0] adr[5] = '{`SCSD_OFS_CHIP_CTRL, `SCSD_OFS_PWR_MON, `SCSD_OFS_CLK_CFG, `SCSD_OFS_CLK_STATUS, 8'h55};
        logic [7:0] rv[5]  = '{8'h01, 8'h00, 8'hFF, 8'hFF, 8'h00};
        logic [7:0] pm[4]  = '{8'h80, 8'h84, 8'h04, 8'h00};
        logic [7:0] cf[4]  = '{8'hFF, 8'h00, 8'h48, 8'h22};
        act = 8'hFF;
        do_reset();
        // Reset values, with a write to an unmapped place first
        wr(8'h55, 8'hA5);
        for (int i = 0; i < 5; i++)
        begin
            rd(adr[i], r);
            chk(r, rv[i]);
        end
        // Brown-out modes, then a random write
        brownout_state <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            d = (i < 4) ? pm[i] : 8'(xs());
            wr(`SCSD_OFS_PWR_MON, d);
            // Mode flop lands one edge after the register
            repeat (2) @(posedge ref_clk);
            chk(bod_sense_on, d[7] & !d[2]);
            chk(lp_rc_run, d[7] & d[2]);
            rd(`SCSD_OFS_PWR_MON, r);
            chk(r, (d & `SCSD_PM_RW_MASK) | 8'h01);
            cnt(120);
            chk(near(n[4], (d[7] & d[2]) ? 120 / (3 * 4) : 0), 1'b1);
        end
        wr(`SCSD_OFS_PWR_MON, 8'h00);
        @(posedge ref_clk);
        // Clock configurations, each applied through a reset
        for (int i = 0; i < 6; i++)
        begin
            d = (i < 4) ? cf[i] : 8'(xs());
            xtal_half <= 4'h5 + 4'(xs() % 4);
            rc_per    <= 4'h2 + 4'(xs() % 4);
            wr(`SCSD_OFS_CLK_CFG, d);
            rd(`SCSD_OFS_CLK_STATUS, r);
            chk(r, act);
            do_reset();
            act = d | `SCSD_CFG_RSVD_MASK;
            c   = act;
            rd(`SCSD_OFS_CLK_STATUS, r);
            chk(r, act);
            chk(crystal_gain_sel, c.crystal_gain_sel);
            chk(filter_active, c.input_clk_filter_en);
            chk(crystal_amp_en, c.osc_source_sel);
            chk(rc_osc_run, !c.osc_source_sel);
            cnt(N);
            chk(near(n[0], c.osc_source_sel ? N / (2 * xtal_half) :
                c.rc_freq_sel ? N / rc_per : N / (2 * rc_per)), 1'b1);
            chk(c.cycle_mode_sel ? near(n[1], n[0] / 2) : n[1] == n[0], 1'b1);
            chk(near(n[2], n[1] / 6), 1'b1);
            chk(n[3], 0);
            if (c.osc_source_sel)
            begin
                xtal_half <= 4'h0;
                repeat (8) @(posedge ref_clk);
                glitch <= 1'b1;
                @(posedge ref_clk);
                glitch <= 1'b0;
                cnt(12);
                chk(n[0], c.input_clk_filter_en ? 0 : 1);
            end
        end
        // Programming enable on a crystal-clocked part
        wr(`SCSD_OFS_CLK_CFG, 8'hFF);
        do_reset();
        wr(`SCSD_OFS_CHIP_CTRL, 8'hF2);
        @(posedge ref_clk);
        chk(software_reset_trig, 1'b1);
        chk(rc_osc_run, 1'b1);
        rd(`SCSD_OFS_CHIP_CTRL, r);
        chk(r, 8'h72);
        cnt(N);
        chk(near(n[3], N / rc_per), 1'b1);
        wr(`SCSD_OFS_CHIP_CTRL, 8'h01);
        @(posedge ref_clk);
        chk(rc_osc_run, 1'b0);
        summarize();
    end
endmodule
